// ### rtl/css_pkg.sv
// shared constants and types of the charge state sequencer
`default_nettype none
package css_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0; // mode enable, watchdog enable
  localparam logic [3:0] REG_WDCLR = 4'h1; // watchdog clear field
  localparam logic [3:0] REG_STATUS = 4'h2; // ok flags and charger detail
  localparam logic [3:0] REG_IRQ = 4'h3; // bypass detail, read only
  localparam logic [3:0] REG_ILIM = 4'h4; // primary current limit
  localparam logic [3:0] REG_STATE = 4'h5; // raw state code
  // field positions
  localparam int CTRL_CHG_EN = 0;
  localparam int CTRL_WD_EN = 1;
  localparam int IRQ_CHG = 0;
  localparam int IRQ_BYP = 1;
  localparam logic [7:0] WDCLR_KEY = 8'h01;
  // charger detail codes
  localparam logic [3:0] DTL_DEAD = 4'h0;
  localparam logic [3:0] DTL_FCC = 4'h1;
  localparam logic [3:0] DTL_FCV = 4'h2;
  localparam logic [3:0] DTL_TFLT = 4'h6;
  localparam logic [3:0] DTL_WDOG = 4'hB;
  localparam logic [3:0] DTL_OFF = 4'h8;
  localparam logic [3:0] DTL_LOWB = 4'h0;
  localparam logic [3:0] BYP_VREG = 4'h8; // top bit of bypass detail
  // limit reset value, off threshold and charge current levels
  localparam logic [6:0] ILIM_RST = 7'h0A;
  localparam logic [6:0] ILIM_OFF = 7'h01; // about 50mA, off threshold
  localparam logic [7:0] ICHG_FULL = 8'hFF;
  localparam logic [7:0] ICHG_FOLD = 8'h80;
  // timing: clock 10 MHz
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_US = 30;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int PQ_MS = 30;
  localparam int PQ_CYC = PQ_MS * (CLK_HZ / 1000);
  localparam int FC_MS = 300;
  localparam int FC_CYC = FC_MS * (CLK_HZ / 1000);
  localparam int WD_MS = 80;
  localparam int WD_CYC = WD_MS * (CLK_HZ / 1000);
  // charge states, one-hot
  typedef enum logic [6:0] {
    ST_OFF = 7'h01, ST_DEAD = 7'h02, ST_LOWB = 7'h04, ST_FCC = 7'h08,
    ST_FCV = 7'h10, ST_TFLT = 7'h20, ST_WDOG = 7'h40
  } css_state_e;
  // comparator bundle
  typedef struct packed {
    logic input_valid;   // primary_input judged valid
    logic below_dead;    // below dead_battery_threshold
    logic below_low;     // below low_battery_threshold
    logic at_reg;        // at battery_regulation_threshold
    logic die_hot;       // die above regulation temperature
    logic vin_low;       // input below primary_voltage_target
    logic batt_absent;   // battery removed
    logic sys_uvlo;      // sys below system_undervoltage_level
  } css_sense_s;
  // status bundle
  typedef struct packed {
    logic charger_ok_flag;
    logic [3:0] charger_detail;
    logic bypass_ok_flag;
    logic [3:0] bypass_detail;
  } css_status_s;
endpackage
`default_nettype wire

// ### rtl/css_top.sv
// charge state sequencer: states, timers, status and register port
// Behaviour
// - lower current limit while input voltage low
// - open pass switch at off current
// - regulation start: bypass irq, ok clear, detail
// - disable or invalid input forces off state
// - off dwell: irq, ok set, code 08
// - off state: zero current, timers zeroed
// - leave off only when valid and enabled
// - dead battery prequal, dwell, code 00
// - above dead threshold go low prequal
// - prequal or cc overtime goes timer fault
// - watchdog expiry goes watchdog suspend
// - cc state, dwell, code 01
// - regulation threshold moves cc to cv
// - hot die reduces fast charge current
// - cv dwell: irq, ok set, code 02
// - order prequal, fast charge, onward
// - no battery, low sys: discharge paths
// - timer fault: instant irq, ok clear, 06
// - watchdog clear write restarts count
// - fault left by mode toggle or replug
`default_nettype none
module css_top #(
  parameter int DWELL_CYC = css_pkg::DEBOUNCE_CYC,
  parameter int PQ_LIMIT = css_pkg::PQ_CYC,
  parameter int FC_LIMIT = css_pkg::FC_CYC,
  parameter int WD_LIMIT = css_pkg::WD_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // comparator inputs
  input wire css_pkg::css_sense_s sense,
  // analog commands
  output logic [7:0] charge_current,
  output logic [6:0] primary_current_limit,
  output logic input_pass_switch,
  output logic batt_discharge_en,
  output logic sys_discharge_en,
  // status
  output css_pkg::css_status_s status,
  output logic charger_irq,
  output logic bypass_irq
);
  css_pkg::css_state_e state_q, state_d; // charge state
  logic [31:0] dwell_q; // cycles in current state
  logic [31:0] timer_q; // charge timer
  logic [31:0] wd_q; // watchdog count
  logic chg_en_q, wd_en_q; // control bits
  logic [6:0] ilim_q; // host programmed limit
  logic vreg_q; // regulation active, registered
  logic dwell_post_q; // dwell event posted for this state
  logic wd_clr, state_chg, wd_exp, dwell_done;

  // host write of the clear key restarts the watchdog
  assign wd_clr = reg_wr && reg_addr == css_pkg::REG_WDCLR &&
                  reg_wdata == css_pkg::WDCLR_KEY;
  assign state_chg = state_d != state_q;
  assign wd_exp = wd_en_q && wd_q >= WD_LIMIT - 1;
  assign dwell_done = dwell_q == DWELL_CYC - 1 && !dwell_post_q;

  // charging target state from battery level
  function automatic css_pkg::css_state_e chg_target(
      input css_pkg::css_sense_s s);
    if (s.below_dead) begin
      chg_target = css_pkg::ST_DEAD;
    end else if (s.below_low) begin
      chg_target = css_pkg::ST_LOWB;
    end else if (s.at_reg) begin
      chg_target = css_pkg::ST_FCV;
    end else begin
      chg_target = css_pkg::ST_FCC;
    end
  endfunction

  // next state logic
  always_comb begin
    state_d = state_q;
    if (!chg_en_q || !sense.input_valid) begin
      state_d = css_pkg::ST_OFF;
    end else begin
      unique case (state_q)
        css_pkg::ST_OFF: begin
          state_d = chg_target(sense);
        end
        css_pkg::ST_DEAD, css_pkg::ST_LOWB: begin
          if (wd_exp) begin
            state_d = css_pkg::ST_WDOG;
          end else if (timer_q >= PQ_LIMIT - 1) begin
            state_d = css_pkg::ST_TFLT;
          end else if (state_q == css_pkg::ST_DEAD && !sense.below_dead) begin
            state_d = css_pkg::ST_LOWB;
          end else if (state_q == css_pkg::ST_LOWB && !sense.below_low) begin
            state_d = css_pkg::ST_FCC;
          end
        end
        css_pkg::ST_FCC: begin
          if (wd_exp) begin
            state_d = css_pkg::ST_WDOG;
          end else if (timer_q >= FC_LIMIT - 1) begin
            state_d = css_pkg::ST_TFLT;
          end else if (sense.at_reg) begin
            state_d = css_pkg::ST_FCV;
          end
        end
        css_pkg::ST_FCV: begin
          if (wd_exp) begin
            state_d = css_pkg::ST_WDOG;
          end
        end
        css_pkg::ST_TFLT: begin
          state_d = css_pkg::ST_TFLT;
        end
        css_pkg::ST_WDOG: begin
          if (wd_clr) begin
            state_d = chg_target(sense);
          end
        end
        default: state_d = css_pkg::ST_OFF;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= css_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // dwell counter restarts on every state change
  always_ff @(posedge sys_clk) begin
    if (!rstn || state_chg) begin
      dwell_q <= '0;
      dwell_post_q <= 1'b0;
    end else if (dwell_done) begin
      dwell_post_q <= 1'b1;
    end else begin
      dwell_q <= dwell_q + 32'h1;
    end
  end

  // charge timer: zero when off, restarts per prequal or fast phase
  always_ff @(posedge sys_clk) begin
    if (!rstn || state_q == css_pkg::ST_OFF) begin
      timer_q <= '0;
    end else if (state_chg && !(state_q == css_pkg::ST_DEAD &&
                 state_d == css_pkg::ST_LOWB)) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_q + 32'h1;
    end
  end

  // watchdog: zero when off, restarted by clear writes
  always_ff @(posedge sys_clk) begin
    if (!rstn || state_q == css_pkg::ST_OFF || wd_clr || !wd_en_q) begin
      wd_q <= '0;
    end else if (!wd_exp) begin
      wd_q <= wd_q + 32'h1;
    end
  end

  // control registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      chg_en_q <= 1'b1;
      wd_en_q <= 1'b0;
      ilim_q <= css_pkg::ILIM_RST;
    end else if (reg_wr) begin
      if (reg_addr == css_pkg::REG_CTRL) begin
        chg_en_q <= reg_wdata[css_pkg::CTRL_CHG_EN];
        wd_en_q <= reg_wdata[css_pkg::CTRL_WD_EN];
      end
      if (reg_addr == css_pkg::REG_ILIM) begin
        ilim_q <= reg_wdata[6:0];
      end
    end
  end

  // input voltage regulation: step the limit down while input sags
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      primary_current_limit <= css_pkg::ILIM_RST;
      input_pass_switch <= 1'b0;
      vreg_q <= 1'b0;
    end else begin
      vreg_q <= sense.vin_low && sense.input_valid;
      if (!sense.input_valid) begin
        primary_current_limit <= ilim_q;
        input_pass_switch <= 1'b0;
      end else if (sense.vin_low) begin
        if (primary_current_limit > css_pkg::ILIM_OFF) begin
          primary_current_limit <= primary_current_limit - 7'h1;
        end else begin
          input_pass_switch <= 1'b0;
        end
      end else begin
        // recovery restores the host programmed limit at once
        primary_current_limit <= ilim_q;
        input_pass_switch <= 1'b1;
      end
    end
  end

  // charge current command and self-discharge paths
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      charge_current <= '0;
      batt_discharge_en <= 1'b0;
      sys_discharge_en <= 1'b0;
    end else begin
      batt_discharge_en <= sense.batt_absent && sense.sys_uvlo;
      sys_discharge_en <= sense.batt_absent && sense.sys_uvlo;
      unique case (state_d)
        css_pkg::ST_FCC, css_pkg::ST_FCV, css_pkg::ST_DEAD,
        css_pkg::ST_LOWB: begin
          charge_current <= sense.die_hot ? css_pkg::ICHG_FOLD
                                          : css_pkg::ICHG_FULL;
        end
        default: charge_current <= '0;
      endcase
    end
  end

  // charger status and interrupt event
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status.charger_ok_flag <= 1'b0;
      status.charger_detail <= css_pkg::DTL_OFF;
      charger_irq <= 1'b0;
    end else begin
      charger_irq <= 1'b0;
      if (state_chg && (state_d == css_pkg::ST_TFLT ||
                        state_d == css_pkg::ST_WDOG)) begin
        charger_irq <= 1'b1;
        status.charger_ok_flag <= 1'b0;
        status.charger_detail <= state_d == css_pkg::ST_TFLT ?
          css_pkg::DTL_TFLT : css_pkg::DTL_WDOG;
      end else if (dwell_done && !state_chg && state_q != css_pkg::ST_TFLT
                   && state_q != css_pkg::ST_WDOG) begin
        // fault and suspend already reported on entry, no dwell event
        charger_irq <= 1'b1;
        status.charger_ok_flag <= 1'b1;
        unique case (state_q)
          css_pkg::ST_OFF: status.charger_detail <= css_pkg::DTL_OFF;
          css_pkg::ST_FCC: status.charger_detail <= css_pkg::DTL_FCC;
          css_pkg::ST_FCV: status.charger_detail <= css_pkg::DTL_FCV;
          default: status.charger_detail <= css_pkg::DTL_DEAD;
        endcase
      end
    end
  end

  // bypass status on regulation start and end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status.bypass_ok_flag <= 1'b1;
      status.bypass_detail <= '0;
      bypass_irq <= 1'b0;
    end else begin
      bypass_irq <= 1'b0;
      if (sense.vin_low && sense.input_valid && !vreg_q) begin
        bypass_irq <= 1'b1;
        status.bypass_ok_flag <= 1'b0;
        status.bypass_detail <= css_pkg::BYP_VREG;
      end else if (!sense.vin_low && vreg_q) begin
        bypass_irq <= 1'b1;
        status.bypass_ok_flag <= 1'b1;
        status.bypass_detail <= '0;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        css_pkg::REG_CTRL: reg_rdata <= {6'h00, wd_en_q, chg_en_q};
        css_pkg::REG_STATUS: reg_rdata <= {status.charger_ok_flag,
          status.bypass_ok_flag, 2'h0, status.charger_detail};
        css_pkg::REG_IRQ: reg_rdata <= {4'h0, status.bypass_detail};
        css_pkg::REG_ILIM: reg_rdata <= {1'b0, primary_current_limit};
        css_pkg::REG_STATE: reg_rdata <= {1'b0, state_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // checks
  sequence s_fault_entry;
    state_q != css_pkg::ST_TFLT ##1 state_q == css_pkg::ST_TFLT;
  endsequence
  a_fault_irq_now: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_fault_entry |-> charger_irq && !status.charger_ok_flag
      && status.charger_detail == css_pkg::DTL_TFLT)
    else $error("timer fault not reported at once");
  a_off_forced: assert property (@(posedge sys_clk) disable iff (!rstn)
    !sense.input_valid |=> state_q == css_pkg::ST_OFF)
    else $error("invalid input did not force off");
  a_off_zero_cur: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == css_pkg::ST_OFF ##1 state_q == css_pkg::ST_OFF
      |-> charge_current == 8'h00 && timer_q == 0 && wd_q == 0)
    else $error("off state not idle");
  a_cc_to_cv: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == css_pkg::ST_FCC && sense.at_reg && chg_en_q
      && sense.input_valid && !wd_exp && timer_q < FC_LIMIT - 1
      |=> state_q == css_pkg::ST_FCV)
    else $error("cc did not advance to cv");
  a_wd_suspend: assert property (@(posedge sys_clk) disable iff (!rstn)
    wd_exp && chg_en_q && sense.input_valid && state_q == css_pkg::ST_FCV
      |=> state_q == css_pkg::ST_WDOG)
    else $error("watchdog expiry ignored");
  a_wd_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
    wd_clr |=> wd_q == 0)
    else $error("watchdog not restarted");
  a_byp_event: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(sense.vin_low) && sense.input_valid && !vreg_q
      |=> bypass_irq && status.bypass_detail[3])
    else $error("bypass regulation not flagged");
  a_discharge_en: assert property (@(posedge sys_clk) disable iff (!rstn)
    sense.batt_absent && sense.sys_uvlo |=> batt_discharge_en
      && sys_discharge_en)
    else $error("discharge paths not enabled");
endmodule // css_top
`default_nettype wire

// ### verification/css_host.sv
// host model: register port master with watchdog and fault-exit helpers
`default_nettype none
module css_host (
  // clock
  input wire logic sys_clk,
  // register port toward the sequencer
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write; idle lines flip so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  // watchdog service keeps charging alive
  task automatic kick();
    wr(css_pkg::REG_WDCLR, css_pkg::WDCLR_KEY);
  endtask
  // fault exit: program the charger off, then on again
  task automatic toggle(input logic [7:0] ctrl);
    wr(css_pkg::REG_CTRL, 8'h00);
    wr(css_pkg::REG_CTRL, ctrl);
  endtask
endmodule // css_host
`default_nettype wire

// ### verification/tb_css_top.sv
// self-checking bench of the charge state sequencer
`default_nettype none
module tb_css_top;
  timeunit 1ns;
  timeprecision 1ns;
  // shortened counts keep the run brief
  localparam int DW = 20;
  localparam int PQ = 100;
  localparam int FC = 150;
  localparam int WD = 200;
  // comparator bits, msb input valid down to lsb sys undervoltage
  localparam logic [7:0] S_IV = 8'h80;
  localparam logic [7:0] S_DEAD = 8'h40;
  localparam logic [7:0] S_LOW = 8'h20;
  localparam logic [7:0] S_REG = 8'h10;
  localparam logic [7:0] S_HOT = 8'h08;
  localparam logic [7:0] S_VLOW = 8'h04;
  localparam logic [7:0] S_ABS = 8'h02;
  localparam logic [7:0] S_UVLO = 8'h01;
  logic sys_clk;
  logic rstn;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  css_pkg::css_sense_s sense;
  logic [7:0] charge_current;
  logic [6:0] primary_current_limit;
  logic input_pass_switch;
  logic batt_discharge_en;
  logic sys_discharge_en;
  css_pkg::css_status_s status;
  logic charger_irq;
  logic bypass_irq;
  int checks = 0;
  int miscompares = 0;
  css_top #(.DWELL_CYC(DW), .PQ_LIMIT(PQ), .FC_LIMIT(FC), .WD_LIMIT(WD))
  i_css_top (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sense(sense), .charge_current(charge_current),
    .primary_current_limit(primary_current_limit),
    .input_pass_switch(input_pass_switch),
    .batt_discharge_en(batt_discharge_en),
    .sys_discharge_en(sys_discharge_en), .status(status),
    .charger_irq(charger_irq), .bypass_irq(bypass_irq));
  css_host i_css_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // single comparison point, four-state exact
  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_reg(input string what, input logic [3:0] a,
      input logic [7:0] exp);
    logic [7:0] d;
    i_css_host.rd(a, d);
    chk(what, d, exp);
  endtask
  // comparator levels change right after an edge
  task automatic set_sense(input logic [7:0] v);
    @(posedge sys_clk);
    sense <= v;
  endtask
  // bounded wait for an event pulse, returns cycles waited
  task automatic wait_irq(input logic byp, input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (n < lim && (byp ? bypass_irq : charger_irq) !== 1'b1);
  endtask
  // the pulse must land inside a window, not merely eventually
  task automatic irq_win(input string what, input logic byp, input int lo,
      input int hi);
    int n;
    wait_irq(byp, hi + 1, n);
    chk(what, {7'h00, n >= lo && n <= hi}, 8'h01);
  endtask
  // status settles with the event; look one cycle later
  task automatic chk_stat(input logic ok, input logic [3:0] det);
    @(posedge sys_clk);
    #1 chk("chg_status", {3'h0, status.charger_ok_flag,
      status.charger_detail}, {3'h0, ok, det});
  endtask
  task automatic t_off();
    irq_win("off_dwell", 1'b0, DW - 1, DW + 4);
    chk_stat(1'b1, css_pkg::DTL_OFF);
    chk_reg("status_reg", css_pkg::REG_STATUS, 8'hC8);
    chk("off_current", charge_current, 8'h00);
    chk_reg("ctrl", css_pkg::REG_CTRL, 8'h01);
    chk_reg("unmapped", 4'hF, 8'h00);
    chk_reg("state_off", css_pkg::REG_STATE, 8'h01);
    $display("test off done");
  endtask
  // normal order: dead, low prequal, constant current, constant voltage
  task automatic t_charge();
    set_sense(S_IV | S_DEAD | S_LOW);
    irq_win("dead_dwell", 1'b0, DW - 1, DW + 4);
    chk_stat(1'b1, css_pkg::DTL_DEAD);
    set_sense(S_IV | S_LOW);
    irq_win("low_dwell", 1'b0, DW - 1, DW + 4);
    chk_reg("state_low", css_pkg::REG_STATE, 8'h04);
    set_sense(S_IV);
    irq_win("cc_dwell", 1'b0, DW - 1, DW + 4);
    chk_stat(1'b1, css_pkg::DTL_FCC);
    chk_reg("state_cc", css_pkg::REG_STATE, 8'h08);
    chk("full_current", charge_current, css_pkg::ICHG_FULL);
    set_sense(S_IV | S_HOT);
    repeat (3) @(posedge sys_clk);
    chk("hot_current", charge_current, css_pkg::ICHG_FOLD);
    set_sense(S_IV | S_REG);
    irq_win("cv_dwell", 1'b0, DW - 1, DW + 4);
    chk_stat(1'b1, css_pkg::DTL_FCV);
    chk_reg("state_cv", css_pkg::REG_STATE, 8'h10);
    $display("test charge done");
  endtask
  // serviced watchdog holds the state, a missed one suspends
  task automatic t_wdog();
    logic [7:0] d;
    i_css_host.wr(css_pkg::REG_CTRL, 8'h03);
    repeat (3) begin
      repeat (WD / 2) @(posedge sys_clk);
      i_css_host.kick();
    end
    chk_reg("wd_served", css_pkg::REG_STATE, 8'h10);
    irq_win("wd_expire", 1'b0, WD - 8, WD + 4);
    chk_stat(1'b0, css_pkg::DTL_WDOG);
    chk_reg("state_wd", css_pkg::REG_STATE, 8'h40);
    i_css_host.kick();
    // the battery still sits at regulation, so charging resumes in cv
    i_css_host.rd(css_pkg::REG_STATE, d);
    chk("wd_resume", d, 8'h10);
    i_css_host.wr(css_pkg::REG_CTRL, 8'h01);
    $display("test watchdog done");
  endtask
  task automatic t_disable();
    i_css_host.wr(css_pkg::REG_CTRL, 8'h00);
    chk_reg("state_dis", css_pkg::REG_STATE, 8'h01);
    chk("dis_current", charge_current, 8'h00);
    set_sense(8'h00);
    i_css_host.wr(css_pkg::REG_CTRL, 8'h01);
    chk_reg("state_noin", css_pkg::REG_STATE, 8'h01);
    set_sense(S_IV);
    chk_reg("state_back", css_pkg::REG_STATE, 8'h08);
    $display("test disable done");
  endtask
  // input sag: limit walks down to the off level, then the switch opens
  task automatic t_vreg();
    chk("pass_on", {7'h00, input_pass_switch}, 8'h01);
    set_sense(S_IV | S_VLOW);
    irq_win("byp_irq", 1'b1, 1, 4);
    chk("byp_status", {6'h00, status.bypass_ok_flag,
      status.bypass_detail[3]}, 8'h01);
    chk_reg("byp_detail", css_pkg::REG_IRQ, 8'h08);
    repeat (12) @(posedge sys_clk);
    chk("limit_low", {1'b0, primary_current_limit},
      {1'b0, css_pkg::ILIM_OFF});
    chk("pass_off", {7'h00, input_pass_switch}, 8'h00);
    set_sense(S_IV);
    irq_win("byp_clear", 1'b1, 1, 4);
    chk("pass_back", {7'h00, input_pass_switch}, 8'h01);
    chk_reg("bypass_ok_flag", css_pkg::REG_STATUS, 8'hC1);
    chk_reg("byp_none", css_pkg::REG_IRQ, 8'h00);
    // a host write sets the limit that the live value returns to
    i_css_host.wr(css_pkg::REG_ILIM, 8'h14);
    chk_reg("limit_host", css_pkg::REG_ILIM, 8'h14);
    $display("test input regulation done");
  endtask
  // overtime in prequal or constant current ends in timer fault
  task automatic t_fault(input logic [7:0] v, input int lim,
      input logic [3:0] code, input logic [7:0] st, input logic plug);
    int n1;
    int n2;
    set_sense(8'h00);
    repeat (3) @(posedge sys_clk);
    set_sense(v);
    wait_irq(1'b0, DW + 5, n1);
    chk_stat(1'b1, code);
    wait_irq(1'b0, lim + 5, n2);
    chk("fault_time", {7'h00, n1 + n2 + 1 >= lim - 1 &&
      n1 + n2 + 1 <= lim + 5}, 8'h01);
    chk_stat(1'b0, css_pkg::DTL_TFLT);
    chk_reg("state_flt", css_pkg::REG_STATE, 8'h20);
    // leave the fault either by pulling the input or by a mode toggle
    if (plug) begin
      set_sense(8'h00);
      set_sense(v);
    end else begin
      i_css_host.toggle(8'h01);
    end
    chk_reg("flt_exit", css_pkg::REG_STATE, st);
    $display("test timer fault done");
  endtask
  task automatic t_discharge();
    set_sense(S_ABS | S_UVLO);
    repeat (3) @(posedge sys_clk);
    chk("dis_both", {6'h00, batt_discharge_en, sys_discharge_en},
      8'h03);
    set_sense(S_ABS);
    repeat (3) @(posedge sys_clk);
    chk("dis_none", {6'h00, batt_discharge_en, sys_discharge_en},
      8'h00);
    $display("test discharge done");
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    sense = '0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    t_off();
    t_charge();
    t_wdog();
    t_disable();
    t_vreg();
    t_fault(S_IV | S_DEAD | S_LOW, PQ, css_pkg::DTL_DEAD, 8'h02, 1'b0);
    t_fault(S_IV, FC, css_pkg::DTL_FCC, 8'h08, 1'b1);
    t_discharge();
    give_verdict();
  end
  // hang guard, well beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
endmodule // tb_css_top
`default_nettype wire
